// ### core/ext_irq_regs.vh
// register indices, field positions and reset values of the external interrupt unit
`ifndef EXT_IRQ_REGS_VH
`define EXT_IRQ_REGS_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_TOGGLE_FLAG 7'h3B
`define IDX_EXT_IRQ_FLAG 7'h3C
`define IDX_EXT_IRQ_ENABLE 7'h3D
`define IDX_PIN_CHANGE_CONTROL 7'h68
`define IDX_EXT_IRQ_SENSE_CONTROL 7'h69
`define IDX_TOGGLE_SELECT_ZERO 7'h6B
`define IDX_TOGGLE_SELECT_ONE 7'h6C
`define IDX_TOGGLE_SELECT_TWO 7'h6D
`define IDX_TOGGLE_SELECT_THREE 7'h73

// ------------------------------------------------------------
// writable bits of each register
// ------------------------------------------------------------
`define MASK_TOGGLE_FLAG 8'h0F
`define MASK_EXT_IRQ_FLAG 8'h01
`define MASK_EXT_IRQ_ENABLE 8'h01
`define MASK_PIN_CHANGE_CONTROL 8'h0F
`define MASK_SENSE_CONTROL 8'h03
`define MASK_SELECT_ZERO 8'h0F
`define MASK_SELECT_ONE 8'h08
`define MASK_SELECT_TWO 8'hF7
`define MASK_SELECT_THREE 8'h0F

// ------------------------------------------------------------
// reset value shared by every register
// ------------------------------------------------------------
`define REG_RESET 8'h00

// ------------------------------------------------------------
// sense select encodings
// ------------------------------------------------------------
`define SENSE_LOW_LEVEL 2'h0
`define SENSE_ANY_EDGE 2'h1
`define SENSE_FALLING 2'h2
`define SENSE_RISING 2'h3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_SENSED 0
`define SEL_ONE_PIN 3
`define GRP3_HI 27
`define GRP3_LO 24
`define GRP2_HI 23
`define GRP2_LO 16
`define GRP1_PIN 11
`define GRP0_HI 3
`define GRP0_LO 0

// ------------------------------------------------------------
// timing: least pulse width on the sensed pin
// ------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define T_INT_NS 50
`define T_INT_CYCLES ((`T_INT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### core/pin_edge_detect.v
// sampled edge detector for a vector of pins
module pin_edge_detect #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // pin levels
  input wire [W-1:0] pin_i,
  // edge pulses
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);

  // ------------------------------------------------------------
  // previous sample and first-sample guard
  // ------------------------------------------------------------
  reg [W-1:0] prev_r;
  reg primed_r;

  // keep last level; first sample after reset gives no edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= {W{1'b0}};
      primed_r <= 1'b0;
    end else begin
      prev_r <= pin_i;
      primed_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // edge decode
  // ------------------------------------------------------------
  assign rise_o = {W{primed_r}} & pin_i & ~prev_r;
  assign fall_o = {W{primed_r}} & ~pin_i & prev_r;

endmodule // pin_edge_detect

// ### core/external_pin_interrupts.v
// external pin interrupt unit with wishbone register slave
//
// Summary of operation
// R1 - pins sensed even while driven as outputs
// R2 - four pin-change groups over fixed pin ranges
// R3 - only mask-selected pins feed group requests
// R4 - pin changes detected without i/o clock
// R5 - sense select: low, any, falling, rising
// R6 - low level requests while pin stays low
// R7 - level and edges detected without i/o clock
// R8 - short wake level gives no interrupt
// R9 - pulses over minimum width always caught
// R10 - source holds low level past instruction
// R11 - software disables before changing sense select
// R12 - sensed request needs enable and global enable
// R13 - flag sets on event; vector only enabled
// R14 - flag cleared by routine or writing one
// R15 - flag held zero in low-level mode
// R16 - sleep with disabled pin may set flag
// R17 - group three needs group and global enable
// R18 - groups two to zero enabled likewise
// R19 - group flags set on request, cleared likewise
// R20 - reserved bits read zero, ignore writes
//
// Chosen here: the Wishbone interface to the registers.
`include "ext_irq_regs.vh"

module external_pin_interrupts #(
  parameter NPINS = 28
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [8:2] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  // device pins
  input wire sensed_irq_pin_i,
  input wire [NPINS-1:0] toggle_watch_inputs_i,
  // cpu side
  input wire global_irq_enable_i,
  input wire sleep_i,
  input wire sensed_ack_i,
  input wire [3:0] toggle_group_ack_i,
  output wire sensed_irq_o,
  output wire toggle_group_three_request_o,
  output wire [2:0] toggle_group_request_o,
  output wire wake_o
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------

  // edge choice of the sense select
  function sense_hit;
    input [1:0] mode;
    input rise;
    input fall;
    begin
      case (mode)
        `SENSE_ANY_EDGE: sense_hit = rise | fall;
        `SENSE_FALLING: sense_hit = fall;
        `SENSE_RISING: sense_hit = rise;
        default: sense_hit = 1'b0;
      endcase
    end
  endfunction

  // write-one-to-clear with set winning over clear
  function [7:0] w1c_update;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      w1c_update = (cur & ~clr) | set;
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] ext_irq_flag_r;
  reg [7:0] ext_irq_flag_nxt;
  reg [7:0] toggle_flag_r;
  reg [7:0] toggle_flag_nxt;
  reg [7:0] ext_irq_enable_r;
  reg [7:0] pin_change_control_r;
  reg [7:0] ext_irq_sense_control_r;
  reg [7:0] toggle_pin_select_zero_r;
  reg [7:0] toggle_pin_select_one_r;
  reg [7:0] toggle_pin_select_two_r;
  reg [7:0] toggle_pin_select_three_r;
  reg ack_r;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire bus_req;
  wire wr_commit;
  wire [7:0] wbyte;
  wire wlane;

  // request seen; write takes effect on the edge that sees ack
  assign bus_req = cyc_i & stb_i;
  assign wr_commit = bus_req & we_i & ack_r;
  assign wlane = sel_i[0];
  assign wbyte = dat_i[7:0];

  wire wr_flag;
  wire wr_toggle_flag;
  wire wr_enable;
  wire wr_control;
  wire wr_sense;
  wire wr_sel0;
  wire wr_sel1;
  wire wr_sel2;
  wire wr_sel3;

  // per-register write strobes on byte lane 0
  assign wr_flag = wr_commit & wlane & (adr_i == `IDX_EXT_IRQ_FLAG);
  assign wr_toggle_flag = wr_commit & wlane & (adr_i == `IDX_TOGGLE_FLAG);
  assign wr_enable = wr_commit & wlane & (adr_i == `IDX_EXT_IRQ_ENABLE);
  assign wr_control = wr_commit & wlane & (adr_i == `IDX_PIN_CHANGE_CONTROL);
  assign wr_sense = wr_commit & wlane & (adr_i == `IDX_EXT_IRQ_SENSE_CONTROL);
  assign wr_sel0 = wr_commit & wlane & (adr_i == `IDX_TOGGLE_SELECT_ZERO);
  assign wr_sel1 = wr_commit & wlane & (adr_i == `IDX_TOGGLE_SELECT_ONE);
  assign wr_sel2 = wr_commit & wlane & (adr_i == `IDX_TOGGLE_SELECT_TWO);
  assign wr_sel3 = wr_commit & wlane & (adr_i == `IDX_TOGGLE_SELECT_THREE);

  // ------------------------------------------------------------
  // sensed pin path
  // ------------------------------------------------------------
  wire sense_en;
  wire pin_seen;
  wire sensed_rise;
  wire sensed_fall;
  wire level_mode;
  wire sensed_event;
  wire sensed_low;

  // pad level is read back even when the pin drives, see R1
  // buffer off in sleep with the pin disabled reads low, see R16
  assign sense_en = ext_irq_enable_r[`BIT_SENSED];
  assign pin_seen = (sleep_i & ~sense_en) ? 1'b0 : sensed_irq_pin_i;
  assign level_mode = (ext_irq_sense_control_r[1:0] == `SENSE_LOW_LEVEL);
  assign sensed_low = ~pin_seen;

  // every sample is checked, so pulses of one period or more count, see R9
  pin_edge_detect #(
    .W(1)
  ) u_sensed_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_seen),
    .rise_o(sensed_rise),
    .fall_o(sensed_fall)
  );

  // edge choice from the sense select, see R5
  assign sensed_event = sense_hit(ext_irq_sense_control_r[1:0], sensed_rise, sensed_fall);

  // ------------------------------------------------------------
  // pin-change path
  // ------------------------------------------------------------
  wire [NPINS-1:0] pc_rise;
  wire [NPINS-1:0] pc_fall;
  wire [NPINS-1:0] pc_change;
  wire [3:0] group_change;

  // toggles sampled on outputs too, see R1
  pin_edge_detect #(
    .W(NPINS)
  ) u_toggle_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(toggle_watch_inputs_i),
    .rise_o(pc_rise),
    .fall_o(pc_fall)
  );

  assign pc_change = pc_rise | pc_fall;

  // group ranges and per-pin select, see R2 see R3
  assign group_change[3] = |(pc_change[`GRP3_HI:`GRP3_LO] & toggle_pin_select_three_r[3:0]);
  assign group_change[2] = |(pc_change[`GRP2_HI:`GRP2_LO] & toggle_pin_select_two_r);
  assign group_change[1] = pc_change[`GRP1_PIN] & toggle_pin_select_one_r[`SEL_ONE_PIN];
  assign group_change[0] = |(pc_change[`GRP0_HI:`GRP0_LO] & toggle_pin_select_zero_r[3:0]);

  // ------------------------------------------------------------
  // flag next values
  // ------------------------------------------------------------
  reg [7:0] sensed_set;
  reg [7:0] sensed_clr;
  reg [7:0] group_set;
  reg [7:0] group_clr;

  // sensed flag: event sets, routine or write-one clears, see R13 see R14
  always @* begin
    sensed_set = 8'h00;
    sensed_clr = 8'h00;
    sensed_set[`BIT_SENSED] = sensed_event;
    sensed_clr[`BIT_SENSED] = sensed_ack_i;
    if (wr_flag) begin
      sensed_clr = sensed_clr | (wbyte & `MASK_EXT_IRQ_FLAG);
    end
    ext_irq_flag_nxt = w1c_update(ext_irq_flag_r, sensed_set, sensed_clr);
    if (level_mode) begin
      ext_irq_flag_nxt = `REG_RESET; // see R15
    end
  end

  // group flags set by any selected toggle, see R19
  always @* begin
    group_set = {4'h0, group_change};
    group_clr = {4'h0, toggle_group_ack_i};
    if (wr_toggle_flag) begin
      group_clr = group_clr | (wbyte & `MASK_TOGGLE_FLAG);
    end
    toggle_flag_nxt = w1c_update(toggle_flag_r, group_set, group_clr);
  end

  // ------------------------------------------------------------
  // flag registers
  // ------------------------------------------------------------

  // detection runs on every edge with no enable, see R4 see R7
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_flag_r <= `REG_RESET;
      toggle_flag_r <= `REG_RESET;
    end else begin
      ext_irq_flag_r <= ext_irq_flag_nxt;
      toggle_flag_r <= toggle_flag_nxt;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------

  // reserved bits masked off on write, see R20
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_enable_r <= `REG_RESET;
      pin_change_control_r <= `REG_RESET;
      ext_irq_sense_control_r <= `REG_RESET;
    end else begin
      if (wr_enable) begin
        ext_irq_enable_r <= wbyte & `MASK_EXT_IRQ_ENABLE;
      end
      if (wr_control) begin
        pin_change_control_r <= wbyte & `MASK_PIN_CHANGE_CONTROL;
      end
      if (wr_sense) begin
        ext_irq_sense_control_r <= wbyte & `MASK_SENSE_CONTROL;
      end
    end
  end

  // per-pin select masks, see R3 see R20
  always @(posedge clk_i) begin
    if (rst_i) begin
      toggle_pin_select_zero_r <= `REG_RESET;
      toggle_pin_select_one_r <= `REG_RESET;
      toggle_pin_select_two_r <= `REG_RESET;
      toggle_pin_select_three_r <= `REG_RESET;
    end else begin
      if (wr_sel0) begin
        toggle_pin_select_zero_r <= wbyte & `MASK_SELECT_ZERO;
      end
      if (wr_sel1) begin
        toggle_pin_select_one_r <= wbyte & `MASK_SELECT_ONE;
      end
      if (wr_sel2) begin
        toggle_pin_select_two_r <= wbyte & `MASK_SELECT_TWO;
      end
      if (wr_sel3) begin
        toggle_pin_select_three_r <= wbyte & `MASK_SELECT_THREE;
      end
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------

  // unmapped indices read zero
  always @* begin
    case (adr_i)
      `IDX_EXT_IRQ_FLAG: rdata_nxt = ext_irq_flag_r;
      `IDX_TOGGLE_FLAG: rdata_nxt = toggle_flag_r;
      `IDX_EXT_IRQ_ENABLE: rdata_nxt = ext_irq_enable_r;
      `IDX_PIN_CHANGE_CONTROL: rdata_nxt = pin_change_control_r;
      `IDX_EXT_IRQ_SENSE_CONTROL: rdata_nxt = ext_irq_sense_control_r;
      `IDX_TOGGLE_SELECT_ZERO: rdata_nxt = toggle_pin_select_zero_r;
      `IDX_TOGGLE_SELECT_ONE: rdata_nxt = toggle_pin_select_one_r;
      `IDX_TOGGLE_SELECT_TWO: rdata_nxt = toggle_pin_select_two_r;
      `IDX_TOGGLE_SELECT_THREE: rdata_nxt = toggle_pin_select_three_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= bus_req & ~ack_r;
      rdata_r <= rdata_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = {24'h000000, rdata_r}; // upper bits read zero, see R20

  // ------------------------------------------------------------
  // interrupt requests
  // ------------------------------------------------------------
  wire sensed_armed;
  wire [3:0] group_armed;

  // sensed request gated by its enable and the global enable, see R12
  assign sensed_armed = sense_en & global_irq_enable_i;

  // low level asks only while the pin is low, so a short level leaves no
  // request pending once the pin is high again; see R6 see R8 see R10
  assign sensed_irq_o = sensed_armed & (level_mode ? sensed_low : ext_irq_flag_r[`BIT_SENSED]); // see R13

  // group request gated by group and global enable, see R17 see R18
  assign group_armed = pin_change_control_r[3:0] & {4{global_irq_enable_i}};
  assign toggle_group_three_request_o = group_armed[3] & toggle_flag_r[3];
  assign toggle_group_request_o = group_armed[2:0] & toggle_flag_r[2:0];

  // ------------------------------------------------------------
  // wake-up
  // ------------------------------------------------------------

  // wake from an enabled source regardless of the global enable, see R4 see R7
  assign wake_o = (sense_en & (level_mode ? sensed_low : sensed_event))
    | (|(pin_change_control_r[3:0] & group_change));

endmodule // external_pin_interrupts

// ### test/ext_irq_chk.sv
// port assertions for the external pin interrupt unit
module ext_irq_chk #(
  parameter NPINS = 28
) (
  // clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // pins and cpu side
  input wire sensed_irq_pin_i,
  input wire [NPINS-1:0] toggle_watch_inputs_i,
  input wire global_irq_enable_i,
  input wire sleep_i,
  input wire sensed_ack_i,
  input wire [3:0] toggle_group_ack_i,
  input wire sensed_irq_o,
  input wire toggle_group_three_request_o,
  input wire [2:0] toggle_group_request_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] grp3 = toggle_watch_inputs_i[27:24];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // bus handshake
  // ----
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held past one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  ack_answer_a: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o) else $error("ack late");
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000) else $error("upper read bits set");
  // ----
  // request gating and clearing
  // ----
  sensed_gie_a: assert property (
    sensed_irq_o |-> global_irq_enable_i) else $error("sensed request without global enable");
  group_gie_a: assert property (
    (toggle_group_three_request_o || (|toggle_group_request_o)) |-> global_irq_enable_i)
    else $error("group request without global enable");
  sensed_clear_a: assert property (
    (sensed_ack_i && sensed_irq_pin_i && !sleep_i && $past(sensed_irq_pin_i) && $past(sensed_irq_pin_i, 2))
    |=> !sensed_irq_o) else $error("sensed request survives routine");
  group_clear_a: assert property (
    (toggle_group_ack_i[3] && grp3 == $past(grp3) && grp3 == $past(grp3, 2))
    |=> !toggle_group_three_request_o) else $error("group three request survives routine");
  // main scenarios
  cover property (sensed_irq_o);
  cover property (toggle_group_three_request_o);
  cover property (ack_o && we_i);
endmodule // ext_irq_chk

bind external_pin_interrupts ext_irq_chk #(.NPINS(NPINS)) i_ext_irq_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .sensed_irq_pin_i(sensed_irq_pin_i), .toggle_watch_inputs_i(toggle_watch_inputs_i),
  .global_irq_enable_i(global_irq_enable_i), .sleep_i(sleep_i), .sensed_ack_i(sensed_ack_i),
  .toggle_group_ack_i(toggle_group_ack_i), .sensed_irq_o(sensed_irq_o),
  .toggle_group_three_request_o(toggle_group_three_request_o), .toggle_group_request_o(toggle_group_request_o)
);

// ### test/pin_source.sv
// model of the external pins driving the interrupt inputs
module pin_source #(
  parameter NPINS = 28
) (
  // clock
  input wire clk_i,
  // pin levels
  output logic sensed_irq_pin_o,
  output logic [NPINS-1:0] toggle_watch_inputs_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: sensed pin high, toggle pins low
  initial begin
    sensed_irq_pin_o = 1'b1;
    toggle_watch_inputs_o = '0;
  end
  // new level held until the next call, always many samples wide
  task automatic set_level(input logic v);
    @(posedge clk_i);
    sensed_irq_pin_o <= v;
  endtask
  // one toggle of a single pin, held until the next call
  task automatic flip(input int idx);
    @(posedge clk_i);
    toggle_watch_inputs_o[idx] <= ~toggle_watch_inputs_o[idx];
  endtask
endmodule // pin_source

// ### test/external_pin_interrupts_tb.sv
// register and pin tests of the external pin interrupt unit
module external_pin_interrupts_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, global_irq_enable_i, sleep_i, sensed_ack_i;
  logic [6:0] adr_i;
  logic [3:0] sel_i, toggle_group_ack_i;
  logic [31:0] dat_i;
  logic [7:0] q;
  wire [31:0] dat_o;
  wire ack_o, sensed_irq_o, req3, wake_o, pin;
  wire [2:0] req;
  wire [27:0] tog;
  int mismatches, cmp_count;
  logic [6:0] idx [10] = '{7'h3B, 7'h3C, 7'h3D, 7'h68, 7'h69, 7'h6B, 7'h6C, 7'h6D, 7'h73, 7'h10};
  logic [7:0] msk [10] = '{8'h00, 8'h00, 8'h01, 8'h0F, 8'h03, 8'h0F, 8'h08, 8'hF7, 8'h0F, 8'h00};
  logic [7:0] sel_bit [4] = '{8'h01, 8'h08, 8'h80, 8'h02};
  int on_pin [4] = '{0, 11, 23, 25};
  int off_pin [4] = '{1, 10, 19, 24};

  pin_source i_pin_source (.clk_i(clk_i), .sensed_irq_pin_o(pin), .toggle_watch_inputs_o(tog));
  external_pin_interrupts i_external_pin_interrupts (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sensed_irq_pin_i(pin), .toggle_watch_inputs_i(tog),
    .global_irq_enable_i(global_irq_enable_i), .sleep_i(sleep_i), .sensed_ack_i(sensed_ack_i),
    .toggle_group_ack_i(toggle_group_ack_i), .sensed_irq_o(sensed_irq_o),
    .toggle_group_three_request_o(req3), .toggle_group_request_o(req), .wake_o(wake_o));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ----
  // report, compare and bus tasks
  // ----
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t request output %b expected %b", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1) begin
      mismatches++;
      $display("BAD %0t bus answer missing", $time);
      print_verdict();
    end else begin
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk8(q, exp);
  endtask
  // mode change with the pin disabled, stale flag cleared
  task automatic sense(input logic [1:0] m);
    wb(1'b1, 7'h3D, 8'h00);
    wb(1'b1, 7'h69, {6'h00, m});
    wb(1'b1, 7'h3C, 8'h01);
    wb(1'b1, 7'h3D, 8'h01);
  endtask
  function automatic logic grp_req(input int g);
    return (g == 3) ? req3 : req[g];
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    cyc_i = 0; stb_i = 0; we_i = 0; adr_i = '0; sel_i = 4'hF; dat_i = '0; rst_i = 1;
    global_irq_enable_i = 1; sleep_i = 0; sensed_ack_i = 0; toggle_group_ack_i = '0;
    mismatches = 0; cmp_count = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, reserved bits and the unmapped index
    for (int i = 0; i < 10; i++) rd(idx[i], 8'h00);
    for (int i = 0; i < 10; i++) begin
      wb(1'b1, idx[i], 8'hFF);
      rd(idx[i], msk[i]);
      wb(1'b1, idx[i], 8'h00);
    end
    // each edge mode against one falling and one rising edge
    for (int m = 1; m < 4; m++) begin
      sense(m[1:0]);
      i_pin_source.set_level(1'b0);
      repeat (3) @(posedge clk_i);
      chk1(sensed_irq_o, m != 3);
      rd(7'h3C, {7'h00, m != 3});
      wb(1'b1, 7'h3C, 8'h01);
      i_pin_source.set_level(1'b1);
      repeat (3) @(posedge clk_i);
      chk1(sensed_irq_o, m != 2);
      rd(7'h3C, {7'h00, m != 2});
      wb(1'b1, 7'h3C, 8'h01);
    end
    // global enable off: flag set but no request until enabled
    global_irq_enable_i <= 1'b0;
    sense(2'h2);
    i_pin_source.set_level(1'b0);
    repeat (3) @(posedge clk_i);
    chk1(sensed_irq_o, 1'b0);
    rd(7'h3C, 8'h01);
    i_pin_source.set_level(1'b1);
    global_irq_enable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1(sensed_irq_o, 1'b1);
    sensed_ack_i <= 1'b1;
    @(posedge clk_i);
    sensed_ack_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(7'h3C, 8'h00);
    // low level mode
    sense(2'h0);
    i_pin_source.set_level(1'b0);
    repeat (3) @(posedge clk_i);
    chk1(sensed_irq_o, 1'b1);
    chk1(wake_o, 1'b1);
    rd(7'h3C, 8'h00);
    i_pin_source.set_level(1'b1);
    repeat (2) @(posedge clk_i);
    chk1(sensed_irq_o, 1'b0);
    // sleep with the pin disabled: buffer off reads low, flag may set
    wb(1'b1, 7'h3D, 8'h00);
    wb(1'b1, 7'h69, 8'h02);
    sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1(sensed_irq_o, 1'b0);
    chk1(wake_o, 1'b0);
    rd(7'h3C, 8'h01);
    sleep_i <= 1'b0;
    wb(1'b1, 7'h3C, 8'h01);
    rd(7'h3C, 8'h00);
    // write with byte lane 0 deselected is ignored
    sel_i <= 4'hE;
    wb(1'b1, 7'h3D, 8'h01);
    sel_i <= 4'hF;
    rd(7'h3D, 8'h00);
    // pin-change groups: masked pin ignored, selected pin flags
    for (int g = 0; g < 4; g++) begin
      wb(1'b1, idx[5 + g], sel_bit[g]);
      wb(1'b1, 7'h68, 8'h01 << g);
      i_pin_source.flip(off_pin[g]);
      repeat (3) @(posedge clk_i);
      rd(7'h3B, 8'h00);
      i_pin_source.flip(on_pin[g]);
      repeat (3) @(posedge clk_i);
      chk1(grp_req(g), 1'b1);
      rd(7'h3B, 8'h01 << g);
      if (g % 2 == 1) begin
        toggle_group_ack_i <= 4'h1 << g;
        @(posedge clk_i);
        toggle_group_ack_i <= 4'h0;
      end else begin
        wb(1'b1, 7'h3B, 8'h01 << g);
      end
      repeat (2) @(posedge clk_i);
      chk1(grp_req(g), 1'b0);
      rd(7'h3B, 8'h00);
      wb(1'b1, idx[5 + g], 8'h00);
    end
    print_verdict();
  end
endmodule // external_pin_interrupts_tb
